// *** core/mmctl_top.sv ***
// memory map control: register bank over axi4-lite plus core address decode
module mmctl_top #(
  parameter logic [7:0] EE_POS_RST    = 8'h01, // eeprom position at reset
  parameter bit         EE_WRITE_ONCE = 1'b0,  // eeprom base write-once
  parameter bit         REG_SW        = 1'b1,  // register space 2K
  parameter logic [1:0] EEP_SW        = 2'b01, // eeprom space code
  parameter logic [2:0] RAM_SW        = 3'b011, // ram space code
  parameter logic [1:0] ROM_SW        = 2'b11, // rom space code
  parameter logic [1:0] PAG_SW        = 2'b11  // page count code
) (
  // clock and reset
  input  logic                          aclk,
  input  logic                          aresetn,
  // operating mode from core
  input  logic                          mode_special,
  input  logic                          mode_emulation,
  input  logic                          mode_expanded,
  // core address
  input  logic                          core_access,
  input  logic [mmctl_pkg::CORE_AW-1:0] core_addr,
  // decode results
  output logic                          sel_regs,
  output logic                          sel_ram,
  output logic                          sel_eeprom,
  output logic                          sel_rom,
  output logic                          rom_window,
  output logic [5:0]                    rom_page,
  output logic                          emulation_select_n,
  output logic                          external_select_n,
  output logic [1:0]                    ext_stretch,
  // axi4-lite write address
  input  logic [mmctl_pkg::AXI_AW-1:0]  awaddr,
  input  logic                          awvalid,
  output logic                          awready,
  // axi4-lite write data
  input  logic [31:0]                   wdata,
  input  logic [3:0]                    wstrb,
  input  logic                          wvalid,
  output logic                          wready,
  // axi4-lite write response
  output logic [1:0]                    bresp,
  output logic                          bvalid,
  input  logic                          bready,
  // axi4-lite read address
  input  logic [mmctl_pkg::AXI_AW-1:0]  araddr,
  input  logic                          arvalid,
  output logic                          arready,
  // axi4-lite read data
  output logic [31:0]                   rdata,
  output logic [1:0]                    rresp,
  output logic                          rvalid,
  input  logic                          rready
);
  import mmctl_pkg::*;

  // all state of the block
  typedef struct packed {
    logic [7:0]       ram_pos;   // ram position
    logic [7:0]       reg_pos;   // register block position
    logic [7:0]       ee_pos;    // eeprom position
    logic [7:0]       misc;      // stretch and rom control
    logic [7:0]       page;      // program page index
    logic             ram_once;  // write-once records
    logic             reg_once;
    logic             ee_once;
    logic             misc_once;
    logic             aw_held;   // write address captured
    logic [IDX_W-1:0] aw_idx;
    logic             w_held;    // write data captured
    logic [7:0]       w_byte;
    logic             w_lane;    // low byte lane enabled
    logic             awready;
    logic             wready;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic             sel_regs;  // registered decode
    logic             sel_ram;
    logic             sel_ee;
    logic             sel_rom;
    logic             rom_win;
    logic [5:0]       rom_page;
    logic             emu_n;
    logic             ext_n;
    logic [1:0]       stretch;
  } mmctl_state_type;

  mmctl_state_type st_reg;   // current state
  mmctl_state_type st_next;  // next state

  // upper address bits of a region match a five-bit base field
  function automatic logic region_hit(input logic [15:0] addr,
                                      input logic [4:0]  base,
                                      input int          rbits);
    logic [15:0] full;
    full = {base, 11'h000};
    region_hit = ((addr ^ full) >> rbits) == 16'h0000;
  endfunction

  // log2 of the ram mappable region for a ram size code
  function automatic int ram_region_bits(input logic [2:0] sw);
    ram_region_bits = 14;
    case (sw)
      3'b000:          ram_region_bits = 11;
      3'b001:          ram_region_bits = 12;
      3'b010, 3'b011:  ram_region_bits = 13;
      default:         ram_region_bits = 14;
    endcase
  endfunction

  // low bits of a word index only matter once it is in range
  function automatic logic idx_mapped(input logic [IDX_W-1:0] idx);
    idx_mapped = (idx >= IDX_RAM_POS && idx <= IDX_TEST_A)
              || idx == IDX_TEST_B || idx == IDX_SIZE_A
              || idx == IDX_SIZE_B || idx == IDX_PAGE
              || idx == IDX_RSVD;
  endfunction

  // write permitted: special modes, or no earlier write
  function automatic logic write_ok(input logic once, input logic special);
    write_ok = special || !once;
  endfunction

  // read mux over the register bank
  function automatic logic [7:0] reg_read(input logic [IDX_W-1:0] idx,
                                          input mmctl_state_type s);
    reg_read = 8'h00;
    case (idx)
      IDX_RAM_POS: reg_read = s.ram_pos & RAM_POS_MASK;
      IDX_REG_POS: reg_read = s.reg_pos & REG_POS_MASK;
      IDX_EE_POS:  reg_read = s.ee_pos & (EE_BASE_MASK | EE_ON_MASK);
      IDX_MISC:    reg_read = s.misc & MISC_MASK;
      IDX_TEST_A:  reg_read = TEST_VALUE;
      IDX_TEST_B:  reg_read = TEST_VALUE;
      IDX_SIZE_A:  reg_read = {REG_SW, 1'b0, EEP_SW, 1'b0, RAM_SW};
      IDX_SIZE_B:  reg_read = {ROM_SW, 4'h0, PAG_SW};
      IDX_PAGE:    reg_read = s.page & PAGE_MASK;
      default:     reg_read = 8'h00;
    endcase
  endfunction

  // decode scratch
  logic [15:0] ram_size;     // allocated ram bytes
  logic [15:0] ram_region;   // mappable region bytes
  logic [15:0] ram_off;      // offset inside region
  logic [15:0] reg_base;     // register block base
  logic        hit_regs;
  logic        hit_ram;
  logic        hit_ee;
  logic        hit_rom;
  logic        internal;
  int          rbits;
  int          ebits;
  logic        do_write;     // both halves of a write present and low byte lane enabled

  // next-state logic: bus slave, register writes and address decode
  always_comb begin
    st_next    = st_reg;
    rbits      = ram_region_bits(RAM_SW);
    ebits      = BLK_SHIFT + int'(EEP_SW) - 1;
    ram_size   = BLOCK_2K * (16'(RAM_SW) + 16'h0001);
    ram_region = 16'(32'h1 << rbits);
    ram_off    = core_addr & (ram_region - 16'h0001);
    reg_base   = {1'b0, st_reg.reg_pos[BASE_HI-1:BASE_LO], 11'h000};
    do_write   = 1'b0;

    // write address channel, taken independently of data
    if (awvalid && st_reg.awready) begin
      st_next.aw_held = 1'b1;
      st_next.aw_idx  = awaddr[IDX_LO +: IDX_W];
    end
    // write data channel, either order
    if (wvalid && st_reg.wready) begin
      st_next.w_held = 1'b1;
      st_next.w_byte = wdata[7:0];
      st_next.w_lane = wstrb[0];
    end

    // both present: perform the write and answer
    if (st_reg.aw_held && st_reg.w_held && !st_reg.bvalid) begin
      do_write        = st_reg.w_lane;
      st_next.aw_held = 1'b0;
      st_next.w_held  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = idx_mapped(st_reg.aw_idx) ? RESP_OKAY : RESP_SLVERR;
    end else if (st_reg.bvalid && bready) begin
      st_next.bvalid = 1'b0; // response accepted
    end

    // register updates; decode reads the stored copy so takes effect next cycle
    if (do_write) begin
      case (st_reg.aw_idx)
        IDX_RAM_POS: begin
          if (write_ok(st_reg.ram_once, mode_special)) begin
            st_next.ram_pos  = st_reg.w_byte & RAM_POS_MASK;
            st_next.ram_once = st_reg.ram_once | !mode_special;
          end
        end
        IDX_REG_POS: begin
          if (write_ok(st_reg.reg_once, mode_special)) begin
            st_next.reg_pos  = st_reg.w_byte & REG_POS_MASK;
            st_next.reg_once = st_reg.reg_once | !mode_special;
          end
        end
        IDX_EE_POS: begin
          // enable bit has no write limit in any mode
          st_next.ee_pos[EEPROM_ENABLE_BIT] = st_reg.w_byte[EEPROM_ENABLE_BIT];
          if (!EE_WRITE_ONCE || write_ok(st_reg.ee_once, mode_special)) begin
            st_next.ee_pos = (st_reg.w_byte & EE_BASE_MASK)
                           | (st_reg.w_byte & EE_ON_MASK);
            st_next.ee_once = st_reg.ee_once | !mode_special;
          end
        end
        IDX_MISC: begin
          if (write_ok(st_reg.misc_once, mode_special)) begin
            st_next.misc      = st_reg.w_byte & MISC_MASK;
            st_next.misc_once = st_reg.misc_once | !mode_special;
          end
        end
        IDX_PAGE: begin
          st_next.page = st_reg.w_byte & PAGE_MASK;
        end
        default: begin
          // test, size and reserved locations ignore writes
          st_next.page = st_next.page;
        end
      endcase
    end

    // ready only while the holding slot is free and no answer waits
    st_next.awready = !st_next.aw_held && !st_next.bvalid;
    st_next.wready  = !st_next.w_held && !st_next.bvalid;

    // read channel: answer one cycle after address is taken
    if (arvalid && st_reg.arready) begin
      st_next.rvalid = 1'b1;
      st_next.rdata  = {24'h000000, reg_read(araddr[IDX_LO +: IDX_W], st_reg)};
      st_next.rresp  = idx_mapped(araddr[IDX_LO +: IDX_W]) ? RESP_OKAY
                                                            : RESP_SLVERR;
    end else if (st_reg.rvalid && rready) begin
      st_next.rvalid = 1'b0;
    end
    st_next.arready = !st_next.rvalid;

    // register block: 2K slots in the lower 32K, 1K used when small
    hit_regs = (core_addr >> BLK_SHIFT) == (reg_base >> BLK_SHIFT)
            && (REG_SW || !core_addr[REG_1K_BIT]);

    // ram: region from base bits, then allocated part low or high
    hit_ram = region_hit(core_addr, st_reg.ram_pos[BASE_HI:BASE_LO], rbits);
    if (st_reg.ram_pos[ALIGN_BIT]) begin
      hit_ram = hit_ram && (ram_off >= (ram_region - ram_size));
    end else begin
      hit_ram = hit_ram && (ram_off < ram_size);
    end

    // eeprom: enabled and a nonzero size configured
    hit_ee = st_reg.ee_pos[EEPROM_ENABLE_BIT] && (EEP_SW != 2'b00)
          && region_hit(core_addr, st_reg.ee_pos[BASE_HI:BASE_LO], ebits);

    // rom when enabled: upper half always, lower fixed page unless masked off
    hit_rom = st_reg.misc[ROM_ENABLE_BIT]
           && (core_addr[ROM_UP_BIT]
           || (core_addr[ROM_LO_BIT] && !st_reg.misc[ROM_UPPER_HALF_ONLY_BIT]));

    // fixed priority: registers, ram, eeprom, rom
    hit_ram  = hit_ram && !hit_regs;
    hit_ee   = hit_ee && !hit_regs && !hit_ram;
    hit_rom  = hit_rom && !hit_regs && !hit_ram && !hit_ee;
    internal = hit_regs || hit_ram || hit_ee || hit_rom;

    // registered selects, qualified by a core access
    st_next.sel_regs = core_access && hit_regs;
    st_next.sel_ram  = core_access && hit_ram;
    st_next.sel_ee   = core_access && hit_ee;
    st_next.sel_rom  = core_access && hit_rom;
    // page window is the lower half of the upper half (third quarter of the map)
    st_next.rom_win  = core_access && hit_rom && core_addr[ROM_UP_BIT]
                    && !core_addr[ROM_LO_BIT];
    st_next.rom_page = st_reg.page[5:0];
    // emulation mode sends rom cycles to the emulator memory
    st_next.emu_n = !(core_access && mode_emulation && hit_rom);
    // expanded or emulation modes reach external space on a miss
    st_next.ext_n = !(core_access && !internal
                   && (mode_expanded || mode_emulation));
    // stretch only means something on external cycles
    st_next.stretch = st_next.ext_n ? 2'b00
                    : st_reg.misc[STR_HI:STR_LO];
  end

  // single register stage, synchronous active-low reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg           <= '0;
      st_reg.ram_pos   <= RAM_POS_RST;
      st_reg.reg_pos   <= REG_POS_RST;
      st_reg.ee_pos    <= EE_POS_RST;
      st_reg.misc      <= MISC_RST;
      st_reg.page      <= PAGE_RST;
      st_reg.ram_once  <= 1'b0;
      st_reg.reg_once  <= 1'b0;
      st_reg.ee_once   <= 1'b0;
      st_reg.misc_once <= 1'b0;
      st_reg.emu_n     <= 1'b1;
      st_reg.ext_n     <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state flops
  assign sel_regs           = st_reg.sel_regs;
  assign sel_ram            = st_reg.sel_ram;
  assign sel_eeprom         = st_reg.sel_ee;
  assign sel_rom            = st_reg.sel_rom;
  assign rom_window         = st_reg.rom_win;
  assign rom_page           = st_reg.rom_page;
  assign emulation_select_n = st_reg.emu_n;
  assign external_select_n  = st_reg.ext_n;
  assign ext_stretch        = st_reg.stretch;
  assign awready            = st_reg.awready;
  assign wready             = st_reg.wready;
  assign bvalid             = st_reg.bvalid;
  assign bresp              = st_reg.bresp;
  assign arready            = st_reg.arready;
  assign rvalid             = st_reg.rvalid;
  assign rdata              = st_reg.rdata;
  assign rresp              = st_reg.rresp;
endmodule // mmctl_top

// *** core/mmctl_pkg.sv ***
// constants for the memory map control register bank and its address decode
// How it works
// - decode core address with operating mode
// - drive active-low emulation and external selects
// - registers sit at module offsets 0x10..0x31
// - ram position write-once unless special mode
// - map changes one cycle after write
// - ram position bits 7:3 give base 15:11
// - high-align bit picks bottom or top alignment
// - register block 1K/2K in first 32K
// - block position bits 6:3, bit 7 zero
// - block position write-once unless special mode
// - eeprom position bits 7:3 give base 15:11
// - eeprom enable bit always writable, maps eeprom
// - eeprom base write rights set at integration
// - eeprom position reset value is a parameter
// - memory size registers read-only, show switches
// - page index register holds six-bit index
// - stretch code adds 0 to 3 cycles
// - test locations readable, writes do nothing
// - register size switch reads 1 for 2K
package mmctl_pkg;
  // bus geometry
  localparam int AXI_AW = 8;
  localparam int IDX_W  = 6;
  localparam int IDX_LO = 2;
  // register indices; byte address is four times these
  localparam logic [IDX_W-1:0] IDX_RAM_POS  = 6'h10;
  localparam logic [IDX_W-1:0] IDX_REG_POS  = 6'h11;
  localparam logic [IDX_W-1:0] IDX_EE_POS   = 6'h12;
  localparam logic [IDX_W-1:0] IDX_MISC     = 6'h13;
  localparam logic [IDX_W-1:0] IDX_TEST_A   = 6'h14;
  localparam logic [IDX_W-1:0] IDX_TEST_B   = 6'h17;
  localparam logic [IDX_W-1:0] IDX_SIZE_A   = 6'h1C;
  localparam logic [IDX_W-1:0] IDX_SIZE_B   = 6'h1D;
  localparam logic [IDX_W-1:0] IDX_PAGE     = 6'h30;
  localparam logic [IDX_W-1:0] IDX_RSVD     = 6'h31;
  // field positions
  localparam int BASE_HI   = 7;
  localparam int BASE_LO   = 3;
  localparam int ALIGN_BIT = 0;
  localparam int EEPROM_ENABLE_BIT  = 0;
  localparam int STR_HI    = 3;
  localparam int STR_LO    = 2;
  localparam int ROM_UPPER_HALF_ONLY_BIT = 1;
  localparam int ROM_ENABLE_BIT = 0;
  // implemented-bit masks
  localparam logic [7:0] RAM_POS_MASK = 8'hF9;
  localparam logic [7:0] REG_POS_MASK = 8'h78;
  localparam logic [7:0] EE_BASE_MASK = 8'hF8;
  localparam logic [7:0] EE_ON_MASK   = 8'h01;
  localparam logic [7:0] MISC_MASK    = 8'h0F;
  localparam logic [7:0] PAGE_MASK    = 8'h3F;
  // reset values
  localparam logic [7:0] RAM_POS_RST = 8'h09;
  localparam logic [7:0] REG_POS_RST = 8'h00;
  localparam logic [7:0] MISC_RST    = 8'h0D;
  localparam logic [7:0] PAGE_RST    = 8'h00;
  localparam logic [7:0] TEST_VALUE  = 8'h00;
  // core address map figures
  localparam int          CORE_AW     = 16;
  localparam int          BLK_SHIFT   = 11;
  localparam int          REG_1K_BIT  = 10;
  localparam int          ROM_UP_BIT  = 15;
  localparam int          ROM_LO_BIT  = 14;
  localparam logic [15:0] BLOCK_2K    = 16'h0800;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : mmctl_pkg

// *** test/mmctl_core_model.sv ***
// core side model: issues one decode address per request
module mmctl_core_model (
  // clock
  input  wire logic        aclk,
  // request from bench
  input  wire logic        go,
  input  wire logic [15:0] addr_in,
  // core bus towards the block
  output logic             core_access,
  output logic [15:0]      core_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial core_access = 1'b0;
  initial core_addr = 16'h0000;
  // idle cycles flip the address so a stale value never decodes by luck
  always @(posedge aclk) begin
    core_access <= go;
    core_addr   <= go ? addr_in : ~core_addr;
  end
endmodule // mmctl_core_model

// *** test/mmctl_sva.sv ***
// checker for the bus handshake and decode outputs of the map control block
module mmctl_sva (
  // clock and reset
  input logic       aclk,
  input logic       aresetn,
  // mode and core bus
  input logic       mode_emulation,
  input logic       mode_expanded,
  input logic       core_access,
  // decode results
  input logic       sel_regs,
  input logic       sel_ram,
  input logic       sel_eeprom,
  input logic       sel_rom,
  input logic       emulation_select_n,
  input logic       external_select_n,
  input logic [1:0] ext_stretch,
  // bus handshake
  input logic       awvalid,
  input logic       awready,
  input logic       wvalid,
  input logic       wready,
  input logic [1:0] bresp,
  input logic       bvalid,
  input logic       bready,
  input logic       arvalid,
  input logic       arready,
  input logic [31:0] rdata,
  input logic       rvalid,
  input logic       rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // both halves of a write taken at one edge
  sequence wr_take; awvalid && awready && wvalid && wready; endsequence
  sequence rd_take; arvalid && arready; endsequence
  wr_answer_a: assert property (wr_take |-> ##[1:2] bvalid)
    else $error("write not answered");
  rd_answer_a: assert property (rd_take |=> rvalid)
    else $error("read not answered");
  b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  ar_block_a: assert property (rvalid |-> !arready)
    else $error("read taken while busy");
  sel_idle_a: assert property (!core_access |=>
    !(sel_regs || sel_ram || sel_eeprom || sel_rom))
    else $error("select without core access");
  sel_single_a: assert property ($onehot0({sel_regs, sel_ram, sel_eeprom, sel_rom}))
    else $error("two selects at once");
  ext_mode_a: assert property (!mode_expanded && !mode_emulation |=> external_select_n)
    else $error("external select in single chip");
  emu_mode_a: assert property (!mode_emulation |=> emulation_select_n)
    else $error("emulation select outside emulation");
  stretch_idle_a: assert property (external_select_n |-> ext_stretch == 2'b00)
    else $error("stretch outside external access");
endmodule // mmctl_sva
bind mmctl_top mmctl_sva chk_u (.aclk, .aresetn, .mode_emulation, .mode_expanded,
  .core_access, .sel_regs, .sel_ram, .sel_eeprom, .sel_rom, .emulation_select_n,
  .external_select_n, .ext_stretch, .awvalid, .awready, .wvalid, .wready, .bresp,
  .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready);

// *** test/tb_top.sv ***
// self-checking bench for the memory map control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import mmctl_pkg::*;
  logic aclk = 0, aresetn = 0, go = 0;          // clock, reset, probe request
  logic mode_special = 0, mode_emulation = 0, mode_expanded = 0;
  logic [15:0] addr_in = 0, core_addr;          // probe address
  logic core_access, sel_regs, sel_ram, sel_eeprom, sel_rom, rom_window;
  logic [5:0] rom_page;
  logic emulation_select_n, external_select_n;
  logic [1:0] ext_stretch, bresp, rresp, got_resp;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, got;
  logic [3:0] wstrb = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  int n_fail = 0, checked = 0, cyc = 0;
  always #10 aclk = ~aclk;
  mmctl_core_model core_u (.aclk(aclk), .go(go), .addr_in(addr_in),
    .core_access(core_access), .core_addr(core_addr));
  mmctl_top dut_u (.aclk(aclk), .aresetn(aresetn), .mode_special(mode_special),
    .mode_emulation(mode_emulation), .mode_expanded(mode_expanded),
    .core_access(core_access), .core_addr(core_addr), .sel_regs(sel_regs),
    .sel_ram(sel_ram), .sel_eeprom(sel_eeprom), .sel_rom(sel_rom),
    .rom_window(rom_window), .rom_page(rom_page), .emulation_select_n(emulation_select_n),
    .external_select_n(external_select_n), .ext_stretch(ext_stretch), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));
  // verdict and end of run
  task summarize();
    $display("checked %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // hang guard: whole run needs far fewer cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_fail++;
      summarize();
    end
  end
  // one comparison, counted
  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // bus write; channels released one by one as each is taken
  task wr(input logic [5:0] idx, input logic [7:0] d, input logic [3:0] s);
    logic fa, fw;
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    wstrb <= s;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    fa = 0;
    fw = 0;
    while (!(fa && fw)) begin
      @(negedge aclk);
      if (awready && !fa) fa = 1;
      if (wready && !fw) fw = 1;
      @(posedge aclk);
      if (fa) awvalid <= 0;
      if (fw) wvalid <= 0;
    end
    while (!bvalid) @(negedge aclk);
    got_resp = bresp;
    @(posedge aclk);
    bready <= 0;
  endtask
  // bus read into got and got_resp
  task rd(input logic [5:0] idx);
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1;
    rready <= 1;
    @(negedge aclk);
    while (!arready) @(negedge aclk);
    @(posedge aclk);
    arvalid <= 0;
    @(negedge aclk);
    while (!rvalid) @(negedge aclk);
    got = rdata;
    got_resp = rresp;
    @(posedge aclk);
    rready <= 0;
  endtask
  // write then read back and compare
  task wrd(input logic [5:0] idx, input logic [7:0] d, input logic [3:0] s,
           input logic [7:0] e);
    wr(idx, d, s);
    rd(idx);
    chk(got, {24'h000000, e});
  endtask
  // one core address through the model, outputs settled after decode edge
  task probe(input logic [15:0] a);
    @(posedge aclk);
    go <= 1;
    addr_in <= a;
    @(posedge aclk);
    go <= 0;
    @(posedge aclk);
    @(negedge aclk);
  endtask
  // reset values and fixed read-only contents
  task t_reset();
    logic [5:0] ix [10];
    logic [7:0] ev [10];
    ix = '{IDX_RAM_POS, IDX_REG_POS, IDX_EE_POS, IDX_MISC, IDX_TEST_A, IDX_TEST_B,
           IDX_SIZE_A, IDX_SIZE_B, IDX_PAGE, IDX_RSVD};
    ev = '{8'h09, 8'h00, 8'h01, 8'h0D, 8'h00, 8'h00, 8'h93, 8'hC3, 8'h00, 8'h00};
    for (int i = 0; i < 10; i++) begin
      rd(ix[i]);
      chk(got, {24'h000000, ev[i]});
      chk(got_resp, RESP_OKAY);
    end
    rd(6'h20);
    chk(got, 32'h00000000);
    chk(got_resp, RESP_SLVERR);
    $display("test reset values done");
  endtask
  // normal mode: single write allowed, eeprom always open
  task t_once();
    wrd(IDX_RAM_POS, 8'h41, 4'h1, 8'h41);
    wrd(IDX_RAM_POS, 8'h11, 4'h1, 8'h41);
    wrd(IDX_REG_POS, 8'h08, 4'h1, 8'h08);
    wrd(IDX_REG_POS, 8'h10, 4'h1, 8'h08);
    wrd(IDX_EE_POS, 8'h80, 4'h1, 8'h80);
    wrd(IDX_EE_POS, 8'h81, 4'h1, 8'h81);
    $display("test write once done");
  endtask
  // special mode: unlimited writes, masks, read-only places
  task t_special();
    mode_special <= 1;
    wrd(IDX_RAM_POS, 8'hFF, 4'h1, 8'hF9);
    wrd(IDX_RAM_POS, 8'h41, 4'h1, 8'h41);
    wrd(IDX_REG_POS, 8'hFF, 4'h1, 8'h78);
    wrd(IDX_REG_POS, 8'h08, 4'h1, 8'h08);
    wrd(IDX_PAGE, 8'hFF, 4'h0, 8'h00);
    wrd(IDX_PAGE, 8'hFF, 4'h1, 8'h3F);
    chk(rom_page, 6'h3F);
    wrd(IDX_SIZE_A, 8'h00, 4'h1, 8'h93);
    wrd(IDX_TEST_A, 8'hFF, 4'h1, 8'h00);
    wrd(IDX_RSVD, 8'hFF, 4'h1, 8'h00);
    wr(6'h20, 8'hFF, 4'h1);
    chk(got_resp, RESP_SLVERR);
    $display("test special mode done");
  endtask
  // decode by position registers and priority
  task t_decode();
    wr(IDX_MISC, 8'h0C, 4'h1);
    probe(16'h0900);
    chk({sel_regs, sel_ram, sel_eeprom, sel_rom}, 4'b1000);
    probe(16'h4100);
    chk({sel_regs, sel_ram, sel_eeprom, sel_rom}, 4'b0100);
    probe(16'h8100);
    chk({sel_regs, sel_ram, sel_eeprom, sel_rom}, 4'b0010);
    wr(IDX_EE_POS, 8'h80, 4'h1);
    probe(16'h8100);
    chk(sel_eeprom, 1'b0);
    wr(IDX_EE_POS, 8'h81, 4'h1);
    wr(IDX_RAM_POS, 8'h01, 4'h1);
    probe(16'h0900);
    chk({sel_regs, sel_ram}, 2'b10);
    probe(16'h1100);
    chk({sel_regs, sel_ram}, 2'b01);
    wr(IDX_MISC, 8'h0D, 4'h1);
    probe(16'hA000);
    chk({sel_rom, rom_window}, 2'b11);
    // lower fixed rom page open, then masked by the upper-half-only bit
    probe(16'h4100);
    chk({sel_rom, rom_window}, 2'b10);
    wr(IDX_MISC, 8'h0F, 4'h1);
    probe(16'h4100);
    chk({sel_rom, rom_window}, 2'b00);
    $display("test decode done");
  endtask
  // external access stretch codes, then emulation select
  task t_stretch();
    mode_expanded <= 1;
    for (int c = 0; c < 4; c++) begin
      wr(IDX_MISC, {4'h0, c[1:0], 2'b00}, 4'h1);
      probe(16'h3000);
      chk({external_select_n, ext_stretch}, {1'b0, c[1:0]});
    end
    mode_expanded <= 0;
    mode_emulation <= 1;
    wr(IDX_MISC, 8'h0D, 4'h1);
    probe(16'hA000);
    chk(emulation_select_n, 1'b0);
    $display("test stretch done");
  endtask
  // mid-run reset: write-once record cleared, one write allowed again
  task t_rerun();
    @(posedge aclk);
    mode_special <= 0;
    mode_emulation <= 0;
    aresetn <= 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(IDX_RAM_POS);
    chk(got, {24'h000000, RAM_POS_RST});
    wrd(IDX_RAM_POS, 8'h21, 4'h1, 8'h21);
    wrd(IDX_RAM_POS, 8'h31, 4'h1, 8'h21);
    $display("test mid reset done");
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    t_reset();
    t_once();
    t_special();
    t_decode();
    t_stretch();
    t_rerun();
    summarize();
  end
endmodule // tb_top
